// *** dv/slc_far_end.sv ***
// model of the remote link partners and the link-side event sources
// assumes the bank's clock; the bench injects events through pulse()
`timescale 1ns/100ps
module slc_far_end (
  // clock
  input wire logic clk,
  // from the bank
  input wire logic [7:0] greetingToken,
  // link events
  output logic [7:0] rxOverflow,
  output logic [7:0] rxIllegal,
  output logic [7:0] creditGained,
  output logic [7:0] creditIssuedEv,
  output logic [7:0] symSent,
  output logic [7:0] tokSent
);
  logic [3:0][7:0] inj = '0;
  logic [3:0][7:0] greetDly = '0;
  logic [7:0] cred = 8'h00;
  assign rxOverflow = inj[0];
  assign rxIllegal = inj[1];
  assign symSent = inj[2];
  assign tokSent = inj[3];
  assign creditGained = cred;
  assign creditIssuedEv = cred;
  // the remote grants credit only after a greeting, a few cycles late
  always @(posedge clk) begin
    greetDly <= {greetDly[2:0], greetingToken};
    cred <= greetDly[3];
  end
  task automatic pulse(input int kind, input int link);
    @(posedge clk);
    inj[kind][link] <= 1'b1;
    @(posedge clk);
    inj[kind][link] <= 1'b0;
  endtask : pulse
endmodule : slc_far_end

// *** dv/slc_regs_sva.sv ***
// port-level assertions for the serial link configuration register bank
// assumes one clock domain with synchronous reset; bound to every slc_regs
`timescale 1ns/100ps
module slc_regs_sva #(
  parameter int NUM_LINKS = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register bus
  input wire logic [9:0] address,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  // link side
  input wire logic [NUM_LINKS-1:0] creditGained,
  input wire logic [NUM_LINKS-1:0] symSent,
  input wire logic [NUM_LINKS-1:0] tokSent,
  input wire logic [NUM_LINKS-1:0] linkEnable,
  input wire logic [NUM_LINKS-1:0] pinOwn,
  input wire logic [NUM_LINKS-1:0] fiveWire,
  input wire logic [NUM_LINKS-1:0] txAllowed,
  input wire logic [NUM_LINKS-1:0] symReady,
  input wire logic [NUM_LINKS-1:0] tokReady,
  input wire logic [NUM_LINKS-1:0] greetingToken,
  input wire logic [NUM_LINKS-1:0] rxRestart,
  input wire logic [NUM_LINKS-1:0] staticForward
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // accepted writes to the first link's control word and to static word 2 (link A)
  logic wr0, wrS;
  assign wr0 = write && !waitrequest && address[9:2] == 8'h80;
  assign wrS = write && !waitrequest && address[9:2] == 8'ha2;
  property p_pin_mux; pinOwn == linkEnable; endproperty
  a_pin_mux: assert property (p_pin_mux) else $error("pin ownership differs from enable");
  property p_en; wr0 && byteenable[3] |=> linkEnable[0] == $past(writedata[31]); endproperty
  a_en: assert property (p_en) else $error("enable bit not taken from write");
  property p_wire; wr0 && byteenable[3] |=> fiveWire[0] == $past(writedata[30]); endproperty
  a_wire: assert property (p_wire) else $error("wire mode not taken from write");
  property p_tx; txAllowed[0] |-> linkEnable[0]; endproperty
  a_tx: assert property (p_tx) else $error("transmit allowed on disabled link");
  property p_gain; creditGained[0] && linkEnable[0] && !(wr0 && byteenable[3]) |=> txAllowed[0];
  endproperty
  a_gain: assert property (p_gain) else $error("credit gained but no transmit");
  property p_greet;
    wr0 && byteenable[3] && writedata[24] && writedata[31] && linkEnable[0]
      |=> greetingToken[0] ##1 !greetingToken[0];
  endproperty
  a_greet: assert property (p_greet) else $error("greeting not a single pulse");
  property p_rxrst; wr0 && byteenable[2] && writedata[23] |=> rxRestart[0] ##1 !rxRestart[0];
  endproperty
  a_rxrst: assert property (p_rxrst) else $error("receiver restart not a single pulse");
  property p_sym; symSent[0] |=> !symReady[0]; endproperty
  a_sym: assert property (p_sym) else $error("symbol gap not started");
  property p_tok; tokSent[0] |=> !tokReady[0]; endproperty
  a_tok: assert property (p_tok) else $error("token gap not started");
  property p_map; wrS && byteenable[3] |=> ##1 staticForward[0] == $past(writedata[31], 2);
  endproperty
  a_map: assert property (p_map) else $error("static word 2 not mapped to link A");
  property p_wait; write && !waitrequest |=> waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("answer lasted more than one cycle");
  c_greet: cover property (greetingToken[0]);
  c_sym: cover property (symSent[0] ##1 !symReady[0]);
  c_map: cover property (wrS);
endmodule : slc_regs_sva

bind slc_regs slc_regs_sva #(.NUM_LINKS(NUM_LINKS)) slc_regs_sva_inst (
  .clk(clk), .srst(srst), .address(address), .write(write), .writedata(writedata),
  .byteenable(byteenable), .waitrequest(waitrequest), .creditGained(creditGained),
  .symSent(symSent), .tokSent(tokSent), .linkEnable(linkEnable), .pinOwn(pinOwn),
  .fiveWire(fiveWire), .txAllowed(txAllowed), .symReady(symReady), .tokReady(tokReady),
  .greetingToken(greetingToken), .rxRestart(rxRestart), .staticForward(staticForward));

// *** dv/slc_regs_tb.sv ***
// self-checking bench for the serial link configuration register bank
// assumes a 100 MHz clock and the far-end model driving all link events
`timescale 1ns/100ps
module slc_regs_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [9:0] address = 10'h000;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest, irq;
  logic [7:0] rxOverflow, rxIllegal, creditGained, creditIssuedEv, symSent, tokSent;
  logic [7:0] linkEnable, pinOwn, fiveWire, txAllowed, symReady, tokReady;
  logic [7:0] greetingToken, rxRestart, staticForward, staticProc;
  logic [7:0][4:0] staticChanEnd;
  int error_cnt = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  slc_regs slc_regs_inst (.clk(clk), .srst(srst), .ce(1'b1), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .rxOverflow(rxOverflow), .rxIllegal(rxIllegal),
    .creditGained(creditGained), .creditIssuedEv(creditIssuedEv), .symSent(symSent),
    .tokSent(tokSent), .linkEnable(linkEnable), .pinOwn(pinOwn), .fiveWire(fiveWire),
    .txAllowed(txAllowed), .symReady(symReady), .tokReady(tokReady),
    .greetingToken(greetingToken), .rxRestart(rxRestart), .staticForward(staticForward),
    .staticProc(staticProc), .staticChanEnd(staticChanEnd));
  slc_far_end far (.clk(clk), .greetingToken(greetingToken), .rxOverflow(rxOverflow),
    .rxIllegal(rxIllegal), .creditGained(creditGained), .creditIssuedEv(creditIssuedEv),
    .symSent(symSent), .tokSent(tokSent));
  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (n >= 100) error_cnt++;
  endtask : bus
  task automatic bus_wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask : bus_wr
  task automatic low_len(input bit tok, output int n);
    n = 0;
    do begin
      @(negedge clk);
      if ((tok ? tokReady[0] : symReady[0]) === 1'b0) n++;
    end while ((tok ? tokReady[0] : symReady[0]) === 1'b0 && n < 50);
  endtask : low_len
  // ==========================================================
  // scenarios
  task automatic t_ctrl();
    logic [31:0] q;
    logic [9:0] a;
    bus(1'b0, 10'h200, 32'h0, 4'hf, q); check(q, 32'h0);
    for (int i = 0; i < 8; i++) begin
      a = 10'h200 + 10'(4 * i);
      bus_wr(a, 32'hf07f_ffff, 4'hf);
      bus(1'b0, a, 32'h0, 4'hf, q); check(q, 32'hc03f_ffff);
      check({linkEnable[i], pinOwn[i], fiveWire[i]}, 32'h7);
      bus_wr(a, 32'h0, 4'h7);
      bus(1'b0, a, 32'h0, 4'hf, q); check(q, 32'hc000_0000);
      bus_wr(a, 32'h0, 4'hf);
      @(negedge clk); check({linkEnable[i], pinOwn[i], fiveWire[i]}, 32'h0);
    end
    bus(1'b0, 10'h3fc, 32'h0, 4'hf, q); check(q, 32'h0);
  endtask : t_ctrl
  task automatic t_greet();
    logic [31:0] q;
    bus_wr(10'h200, 32'h8000_0000, 4'hf);
    bus_wr(10'h200, 32'h8100_0000, 4'hf);
    @(negedge clk); check(greetingToken, 32'h01);
    @(negedge clk); check(greetingToken, 32'h00);
    repeat (10) @(posedge clk);
    bus(1'b0, 10'h200, 32'h0, 4'hf, q); check(q, 32'h8600_0000);
    check(txAllowed, 32'h01);
    bus_wr(10'h200, 32'h0, 4'hf);
    @(negedge clk); check(txAllowed, 32'h00);
  endtask : t_greet
  task automatic t_err_irq();
    logic [31:0] q;
    bus_wr(10'h204, 32'h8000_0000, 4'hf);
    bus_wr(10'h300, 32'h0000_ffff, 4'hf);
    bus_wr(10'h304, 32'h0000_0002, 4'hf);
    far.pulse(0, 1);
    repeat (2) @(negedge clk);
    check(irq, 32'h1);
    bus(1'b0, 10'h204, 32'h0, 4'hf, q); check(q, 32'h8800_0000);
    bus(1'b0, 10'h300, 32'h0, 4'hf, q); check(q, 32'h2);
    bus_wr(10'h300, 32'h2, 4'hf);
    @(negedge clk); check(irq, 32'h0);
    bus_wr(10'h204, 32'h8080_0000, 4'hf);
    @(negedge clk); check(rxRestart, 32'h02);
    bus(1'b0, 10'h204, 32'h0, 4'hf, q); check(q, 32'h8000_0000);
    bus_wr(10'h304, 32'h0, 4'hf);
    far.pulse(1, 1);
    repeat (2) @(negedge clk);
    check(irq, 32'h0);
    bus(1'b0, 10'h204, 32'h0, 4'hf, q); check(q, 32'h8800_0000);
  endtask : t_err_irq
  task automatic t_gap();
    int n;
    bus_wr(10'h200, 32'h8080_1805, 4'hf);
    far.pulse(2, 0);
    low_len(1'b0, n); check(32'(n), 32'd4);
    far.pulse(3, 0);
    low_len(1'b1, n); check(32'(n), 32'd6);
  endtask : t_gap
  task automatic t_static();
    logic [31:0] q;
    logic [2:0] m;
    logic [2:0] lnk [8] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h6, 3'h7, 3'h4, 3'h5};
    for (int w = 0; w < 8; w++) begin
      m = lnk[w];
      bus_wr(10'h280 + 10'(4 * w), 32'hffff_fee0 | 32'(w % 2) << 8 | 32'(w), 4'hf);
      bus(1'b0, 10'h280 + 10'(4 * w), 32'h0, 4'hf, q);
      check(q, 32'h8000_0000 | 32'(w % 2) << 8 | 32'(w));
      check({staticForward[m], staticProc[m]}, 32'(2 + w % 2));
      check(staticChanEnd[m], 32'(w));
    end
  endtask : t_static
  // ==========================================================
  // run control
  task automatic finish_test();
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_ctrl();
    t_greet();
    t_err_irq();
    t_gap();
    t_static();
    finish_test();
  end
  // the whole run needs a few hundred cycles; this is ample
  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end
endmodule : slc_regs_tb

// *** rtl/slc_irq.sv ***
// sticky interrupt status with mask and one level output
// assumes event pulses and write-one-to-clear strobes on clk
`timescale 1ns/100ps
module slc_irq #(
  parameter int WIDTH = slc_pkg::IRQ_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // events and software access
  input wire logic [WIDTH-1:0] events,
  input wire logic [WIDTH-1:0] clearBits,
  input wire logic maskWrite,
  input wire logic [WIDTH-1:0] maskData,
  // state
  output logic [WIDTH-1:0] status,
  output logic [WIDTH-1:0] mask,
  output logic irq
);

  // ==========================================================
  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      status <= '0;
    end else if (ce) begin
      status <= (status & ~clearBits) | events;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mask <= '0;
    end else if (ce && maskWrite) begin
      mask <= maskData;
    end
  end

  assign irq = |(status & mask);

endmodule : slc_irq

// *** rtl/slc_link_chan.sv ***
// per-link credit, error and transmit pacing state
// assumes link-side event pulses are on clk; commands are one-cycle pulses
`timescale 1ns/100ps
module slc_link_chan (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // configuration and commands from the register bank
  input wire logic linkEnable,
  input wire logic [slc_pkg::GAP_W-1:0] symGap,
  input wire logic [slc_pkg::GAP_W-1:0] tokGap,
  input wire logic cmdGreet,
  input wire logic cmdRxReset,
  // events from the link logic
  input wire logic rxOverflow,
  input wire logic rxIllegal,
  input wire logic creditGained,
  input wire logic creditIssuedEv,
  input wire logic symSent,
  input wire logic tokSent,
  // state and commands to the link logic
  output logic errFlag,
  output logic creditIssued,
  output logic creditHeld,
  output logic txAllowed,
  output logic symReady,
  output logic tokReady,
  output logic greetingToken,
  output logic rxRestart
);

  logic [slc_pkg::GAP_W:0] symCnt;
  logic [slc_pkg::GAP_W:0] tokCnt;

  // idle gap is field plus one clocks, counted down to zero
  function automatic logic [slc_pkg::GAP_W:0] pace_next(input logic sent,
      input logic [slc_pkg::GAP_W-1:0] gap, input logic [slc_pkg::GAP_W:0] cnt);
    if (sent) begin
      pace_next = {1'b0, gap} + 1'b1;
    end else if (cnt != '0) begin
      pace_next = cnt - 1'b1;
    end else begin
      pace_next = cnt;
    end
  endfunction : pace_next

  // ==========================================================
  // error flag: receiver reset clears it, a new error wins
  always_ff @(posedge clk) begin
    if (srst) begin
      errFlag <= 1'b0;
    end else if (ce) begin
      if (linkEnable && (rxOverflow || rxIllegal)) begin
        errFlag <= 1'b1;
      end else if (cmdRxReset) begin
        errFlag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // credit state
  always_ff @(posedge clk) begin
    if (srst) begin
      creditHeld <= 1'b0;
      creditIssued <= 1'b0;
    end else if (ce) begin
      if (!linkEnable) begin
        creditHeld <= 1'b0;
        creditIssued <= 1'b0;
      end else begin
        if (creditGained) begin
          creditHeld <= 1'b1;
        end else if (cmdGreet) begin
          creditHeld <= 1'b0;
        end
        if (creditIssuedEv) begin
          creditIssued <= 1'b1;
        end else if (cmdRxReset) begin
          creditIssued <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // command pulses and pacing
  always_ff @(posedge clk) begin
    if (srst) begin
      greetingToken <= 1'b0;
      rxRestart <= 1'b0;
    end else if (ce) begin
      greetingToken <= cmdGreet && linkEnable;
      rxRestart <= cmdRxReset;
    end else begin
      greetingToken <= 1'b0;
      rxRestart <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      symCnt <= '0;
      tokCnt <= '0;
    end else if (ce) begin
      symCnt <= pace_next(symSent, symGap, symCnt);
      tokCnt <= pace_next(tokSent, tokGap, tokCnt);
    end
  end

  assign symReady = (symCnt == '0);
  assign tokReady = (tokCnt == '0);
  // transmitting without credit would overrun the far receiver
  assign txAllowed = linkEnable && creditHeld;

endmodule : slc_link_chan

// *** rtl/slc_pkg.sv ***
// constants shared by the serial link configuration register bank
// assumes a 32-bit register bus and a word index taken from byte address bits 9:2
package slc_pkg;

  // ==========================================================
  // geometry
  localparam int NUM_LINKS = 8;
  localparam int GAP_W = 11;
  localparam int CHAN_W = 5;
  localparam int IDX_W = 8;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] CTRL_BASE_IDX = 8'h80;
  localparam logic [IDX_W-1:0] STATIC_BASE_IDX = 8'ha0;
  localparam logic [IDX_W-1:0] IRQ_STATUS_IDX = 8'hc0;
  localparam logic [IDX_W-1:0] IRQ_MASK_IDX = 8'hc1;

  // ==========================================================
  // link control word fields
  localparam int EN_BIT = 31;
  localparam int WIRE_BIT = 30;
  localparam int ERR_BIT = 27;
  localparam int ISSUED_BIT = 26;
  localparam int HELD_BIT = 25;
  localparam int GREET_BIT = 24;
  localparam int RXRST_BIT = 23;
  localparam int SYMGAP_LSB = 11;
  localparam int TOKGAP_LSB = 0;
  localparam logic RST_EN = 1'b0;
  localparam logic RST_WIRE = 1'b0;
  localparam logic [GAP_W-1:0] RST_GAP = 11'h000;

  // ==========================================================
  // static forwarding word fields
  localparam int STATIC_EN_BIT = 31;
  localparam int PROC_BIT = 8;
  localparam int CHAN_LSB = 0;
  localparam logic [CHAN_W-1:0] RST_CHAN = 5'h00;

  // ==========================================================
  // interrupt status layout: errors low byte, credit gained high byte
  localparam int IRQ_ERR_LSB = 0;
  localparam int IRQ_CRED_LSB = 8;
  localparam int IRQ_W = 16;

  // static words are ordered C, D, A, B, G, H, E, F; links A..H are 0..7
  function automatic logic [2:0] static_link_of_word(input logic [2:0] word);
    case (word)
      3'h0: static_link_of_word = 3'h2;
      3'h1: static_link_of_word = 3'h3;
      3'h2: static_link_of_word = 3'h0;
      3'h3: static_link_of_word = 3'h1;
      3'h4: static_link_of_word = 3'h6;
      3'h5: static_link_of_word = 3'h7;
      3'h6: static_link_of_word = 3'h4;
      default: static_link_of_word = 3'h5;
    endcase
  endfunction : static_link_of_word

endpackage : slc_pkg

// *** rtl/slc_regs.sv ***
// serial link configuration register bank with Avalon-MM slave
// assumes link logic and bus master share clk; link events are one-cycle pulses
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/100ps
module slc_regs #(
  parameter int NUM_LINKS = slc_pkg::NUM_LINKS
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [slc_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [slc_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [slc_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  // interrupt
  output logic irq,
  // events from the link logic, one bit per link
  input wire logic [NUM_LINKS-1:0] rxOverflow,
  input wire logic [NUM_LINKS-1:0] rxIllegal,
  input wire logic [NUM_LINKS-1:0] creditGained,
  input wire logic [NUM_LINKS-1:0] creditIssuedEv,
  input wire logic [NUM_LINKS-1:0] symSent,
  input wire logic [NUM_LINKS-1:0] tokSent,
  // link configuration and commands
  output logic [NUM_LINKS-1:0] linkEnable,
  output logic [NUM_LINKS-1:0] pinOwn,
  output logic [NUM_LINKS-1:0] fiveWire,
  output logic [NUM_LINKS-1:0] txAllowed,
  output logic [NUM_LINKS-1:0] symReady,
  output logic [NUM_LINKS-1:0] tokReady,
  output logic [NUM_LINKS-1:0] greetingToken,
  output logic [NUM_LINKS-1:0] rxRestart,
  // static forwarding, indexed by link A..H
  output logic [NUM_LINKS-1:0] staticForward,
  output logic [NUM_LINKS-1:0] staticProc,
  output logic [NUM_LINKS-1:0][slc_pkg::CHAN_W-1:0] staticChanEnd
);

  // ==========================================================
  // register storage
  logic [NUM_LINKS-1:0][slc_pkg::GAP_W-1:0] symGap;
  logic [NUM_LINKS-1:0][slc_pkg::GAP_W-1:0] tokGap;
  logic [NUM_LINKS-1:0] staticEnWord;
  logic [NUM_LINKS-1:0] staticProcWord;
  logic [NUM_LINKS-1:0][slc_pkg::CHAN_W-1:0] staticChanWord;
  logic [NUM_LINKS-1:0] errFlag;
  logic [NUM_LINKS-1:0] creditIssued;
  logic [NUM_LINKS-1:0] creditHeld;
  logic [NUM_LINKS-1:0] cmdGreet;
  logic [NUM_LINKS-1:0] cmdRxReset;
  logic [slc_pkg::IRQ_W-1:0] irqStatus;
  logic [slc_pkg::IRQ_W-1:0] irqMask;
  logic [slc_pkg::IRQ_W-1:0] irqEvents;
  logic [slc_pkg::IRQ_W-1:0] irqClear;
  logic irqMaskWrite;
  logic [NUM_LINKS-1:0] heldPrev;

  // ==========================================================
  // bus decode
  logic ack;
  logic [slc_pkg::IDX_W-1:0] idx;
  logic [slc_pkg::IDX_W-1:0] ctrlOff;
  logic [slc_pkg::IDX_W-1:0] staticOff;
  logic ctrlHit;
  logic staticHit;
  logic [2:0] linkSel;
  logic [2:0] staticSel;
  logic wrStrobe;
  logic [slc_pkg::DATA_W-1:0] wrMerged;
  logic [slc_pkg::DATA_W-1:0] next_readdata;

  assign idx = address[slc_pkg::ADDR_W-1:2];
  assign ctrlOff = idx - slc_pkg::CTRL_BASE_IDX;
  assign staticOff = idx - slc_pkg::STATIC_BASE_IDX;
  // one word per link from the base upwards
  assign ctrlHit = (idx >= slc_pkg::CTRL_BASE_IDX) && (ctrlOff < NUM_LINKS);
  assign staticHit = (idx >= slc_pkg::STATIC_BASE_IDX) && (staticOff < NUM_LINKS);
  assign linkSel = ctrlOff[2:0];
  assign staticSel = staticOff[2:0];
  // a write lands only at the edge where waitrequest is seen low
  assign wrStrobe = write && ack && ce;

  // byte lanes not enabled keep their old contents
  function automatic logic [slc_pkg::DATA_W-1:0] be_merge(
      input logic [slc_pkg::DATA_W-1:0] oldVal, input logic [slc_pkg::DATA_W-1:0] newVal,
      input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      be_merge[b*8 +: 8] = be[b] ? newVal[b*8 +: 8] : oldVal[b*8 +: 8];
    end
  endfunction : be_merge

  // view of a control word as software sees it
  function automatic logic [slc_pkg::DATA_W-1:0] ctrl_word(input logic en, input logic five,
      input logic err, input logic issued, input logic held,
      input logic [slc_pkg::GAP_W-1:0] sg, input logic [slc_pkg::GAP_W-1:0] tg);
    ctrl_word = '0;
    ctrl_word[slc_pkg::EN_BIT] = en;
    ctrl_word[slc_pkg::WIRE_BIT] = five;
    ctrl_word[slc_pkg::ERR_BIT] = err;
    ctrl_word[slc_pkg::ISSUED_BIT] = issued;
    ctrl_word[slc_pkg::HELD_BIT] = held;
    ctrl_word[slc_pkg::SYMGAP_LSB +: slc_pkg::GAP_W] = sg;
    ctrl_word[slc_pkg::TOKGAP_LSB +: slc_pkg::GAP_W] = tg;
  endfunction : ctrl_word

  function automatic logic [slc_pkg::DATA_W-1:0] static_word(input logic en, input logic proc,
      input logic [slc_pkg::CHAN_W-1:0] chan);
    static_word = '0;
    static_word[slc_pkg::STATIC_EN_BIT] = en;
    static_word[slc_pkg::PROC_BIT] = proc;
    static_word[slc_pkg::CHAN_LSB +: slc_pkg::CHAN_W] = chan;
  endfunction : static_word

  // merged write data against the addressed register's current value
  always_comb begin
    if (ctrlHit) begin
      wrMerged = be_merge(ctrl_word(linkEnable[linkSel], fiveWire[linkSel], 1'b0, 1'b0,
          1'b0, symGap[linkSel], tokGap[linkSel]), writedata, byteenable);
    end else if (staticHit) begin
      wrMerged = be_merge(static_word(staticEnWord[staticSel], staticProcWord[staticSel],
          staticChanWord[staticSel]), writedata, byteenable);
    end else if (idx == slc_pkg::IRQ_MASK_IDX) begin
      wrMerged = be_merge({{(slc_pkg::DATA_W-slc_pkg::IRQ_W){1'b0}}, irqMask}, writedata,
          byteenable);
    end else begin
      wrMerged = be_merge('0, writedata, byteenable);
    end
  end

  // ==========================================================
  // bus handshake: one wait cycle, answer on the second cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      ack <= 1'b0;
    end else if (ce) begin
      ack <= (read || write) && !ack;
    end
  end

  assign waitrequest = !ack;

  always_comb begin
    next_readdata = '0;
    if (ctrlHit) begin
      next_readdata = ctrl_word(linkEnable[linkSel], fiveWire[linkSel], errFlag[linkSel],
          creditIssued[linkSel], creditHeld[linkSel], symGap[linkSel], tokGap[linkSel]);
    end else if (staticHit) begin
      next_readdata = static_word(staticEnWord[staticSel], staticProcWord[staticSel],
          staticChanWord[staticSel]);
    end else if (idx == slc_pkg::IRQ_STATUS_IDX) begin
      next_readdata[slc_pkg::IRQ_W-1:0] = irqStatus;
    end else if (idx == slc_pkg::IRQ_MASK_IDX) begin
      next_readdata[slc_pkg::IRQ_W-1:0] = irqMask;
    end
  end

  // unmapped indices read as zero
  always_ff @(posedge clk) begin
    if (srst) begin
      readdata <= '0;
    end else if (ce && read && !ack) begin
      readdata <= next_readdata;
    end
  end

  // ==========================================================
  // link control words
  always_ff @(posedge clk) begin
    if (srst) begin
      linkEnable <= {NUM_LINKS{slc_pkg::RST_EN}};
      fiveWire <= {NUM_LINKS{slc_pkg::RST_WIRE}};
    end else if (wrStrobe && ctrlHit) begin
      linkEnable[linkSel] <= wrMerged[slc_pkg::EN_BIT];
      fiveWire[linkSel] <= wrMerged[slc_pkg::WIRE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      symGap <= {NUM_LINKS{slc_pkg::RST_GAP}};
      tokGap <= {NUM_LINKS{slc_pkg::RST_GAP}};
    end else if (wrStrobe && ctrlHit) begin
      symGap[linkSel] <= wrMerged[slc_pkg::SYMGAP_LSB +: slc_pkg::GAP_W];
      tokGap[linkSel] <= wrMerged[slc_pkg::TOKGAP_LSB +: slc_pkg::GAP_W];
    end
  end

  // command bits act on the write and are never stored
  always_comb begin
    cmdGreet = '0;
    cmdRxReset = '0;
    if (wrStrobe && ctrlHit) begin
      cmdGreet[linkSel] = byteenable[slc_pkg::GREET_BIT/8] && writedata[slc_pkg::GREET_BIT];
      cmdRxReset[linkSel] = byteenable[slc_pkg::RXRST_BIT/8] &&
          writedata[slc_pkg::RXRST_BIT];
    end
  end

  // shared port pins follow the enable; overlapping links must not both be enabled
  assign pinOwn = linkEnable;

  // ==========================================================
  // static forwarding words
  always_ff @(posedge clk) begin
    if (srst) begin
      staticEnWord <= '0;
      staticProcWord <= '0;
      staticChanWord <= {NUM_LINKS{slc_pkg::RST_CHAN}};
    end else if (wrStrobe && staticHit) begin
      staticEnWord[staticSel] <= wrMerged[slc_pkg::STATIC_EN_BIT];
      staticProcWord[staticSel] <= wrMerged[slc_pkg::PROC_BIT];
      staticChanWord[staticSel] <= wrMerged[slc_pkg::CHAN_LSB +: slc_pkg::CHAN_W];
    end
  end

  // outputs reordered from word order to link letter order
  always_ff @(posedge clk) begin
    if (srst) begin
      staticForward <= '0;
      staticProc <= '0;
      staticChanEnd <= {NUM_LINKS{slc_pkg::RST_CHAN}};
    end else if (ce) begin
      for (int w = 0; w < NUM_LINKS; w++) begin
        staticForward[slc_pkg::static_link_of_word(3'(w))] <= staticEnWord[w];
        staticProc[slc_pkg::static_link_of_word(3'(w))] <= staticProcWord[w];
        staticChanEnd[slc_pkg::static_link_of_word(3'(w))] <= staticChanWord[w];
      end
    end
  end

  // ==========================================================
  // per-link state
  for (genvar g = 0; g < NUM_LINKS; g++) begin : gLink
    slc_link_chan uChan (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .linkEnable(linkEnable[g]),
      .symGap(symGap[g]),
      .tokGap(tokGap[g]),
      .cmdGreet(cmdGreet[g]),
      .cmdRxReset(cmdRxReset[g]),
      .rxOverflow(rxOverflow[g]),
      .rxIllegal(rxIllegal[g]),
      .creditGained(creditGained[g]),
      .creditIssuedEv(creditIssuedEv[g]),
      .symSent(symSent[g]),
      .tokSent(tokSent[g]),
      .errFlag(errFlag[g]),
      .creditIssued(creditIssued[g]),
      .creditHeld(creditHeld[g]),
      .txAllowed(txAllowed[g]),
      .symReady(symReady[g]),
      .tokReady(tokReady[g]),
      .greetingToken(greetingToken[g]),
      .rxRestart(rxRestart[g])
    );
  end

  // ==========================================================
  // interrupts: error events and newly gained credit
  always_ff @(posedge clk) begin
    if (srst) begin
      heldPrev <= '0;
    end else if (ce) begin
      heldPrev <= creditHeld;
    end
  end

  always_comb begin
    irqEvents = '0;
    irqEvents[slc_pkg::IRQ_ERR_LSB +: NUM_LINKS] = linkEnable & (rxOverflow | rxIllegal);
    irqEvents[slc_pkg::IRQ_CRED_LSB +: NUM_LINKS] = creditHeld & ~heldPrev;
  end

  assign irqClear = (wrStrobe && idx == slc_pkg::IRQ_STATUS_IDX) ?
      wrMerged[slc_pkg::IRQ_W-1:0] : '0;
  assign irqMaskWrite = wrStrobe && (idx == slc_pkg::IRQ_MASK_IDX);

  slc_irq #(
    .WIDTH(slc_pkg::IRQ_W)
  ) uIrq (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .events(irqEvents),
    .clearBits(irqClear),
    .maskWrite(irqMaskWrite),
    .maskData(wrMerged[slc_pkg::IRQ_W-1:0]),
    .status(irqStatus),
    .mask(irqMask),
    .irq(irq)
  );

endmodule : slc_regs
